// [src/uie_usart_irq_rx.sv]
// usart event outputs, interrupt vectors and double-buffered receive readout
// Operation
// [R01] in host sync or spi host mode the transfer clock is an event output
// [R02] infrared receive event input is detected as a pulse on clk
// [R03] receive vector from unread data, sleep start or sync error, each enabled
// [R04] tx-empty vector while enabled and transmit buffer empty
// [R05] tx-done flag once frame shifted out and buffer empty
// [R06] flags set regardless of their enable
// [R07] request while enable and flag set, held until flag clears
// [R08] receive low byte shows oldest frame bits 7:0, resets to zero
// [R09] nine-bit low-first: high read advances; otherwise low read advances
// [R10] software reads the non-advancing byte first, then the advancing byte
// [R11] high byte: done bit7, overrun bit6, framing bit2, parity bit1, d8 bit0
// [R12] receive-done flag set while buffer holds data, clears when empty
// [R13] overrun when full, frame waiting, new start; cleared by data read
// [R14] framing error set on stop bit zero, cleared on one
// [R15] parity error set when checking on and frame bad, else cleared
// [R16] nine-bit characters put the ninth data bit at high byte bit 0
// [R17] lin auto-baud: bit 0 reads 0 in identifier, 1 in response
// [R18] lin constrained auto-baud selected by receive mode value 3
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module uie_usart_irq_rx
    import uie_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire uie_bus_t      bus,
    output logic [7:0]         regRdData,
    input  wire logic          rxFrameValid,
    input  wire uie_rx_frame_t rxFrame,
    output logic               rxReady,
    input  wire logic          rxStartBit,
    input  wire logic          rxStartSleep,
    input  wire logic          syncError,
    input  wire logic          breakDetected,
    input  wire logic          txBufEmpty,
    input  wire logic          txShiftDone,
    output logic [8:0]         txData,
    output logic               txLoad,
    input  wire logic          transferClkIn,
    input  wire logic          xckIsOutput,
    output logic               transferClockOut,
    input  wire logic          infraredEventInput,
    output logic               irRxEvent,
    output logic               receiveDoneVector,
    output logic               txBufferEmptyVector,
    output logic               txDoneVector,
    output logic               irq,
    output uie_cfg_t           cfg
);
    uie_state_t    s_q;
    uie_state_t    s_d;
    logic [1:0]    mode;
    logic          spiHost;
    logic          nineLow;
    logic          linMode;
    logic          pop;
    logic          push;
    logic          wStat;
    uie_rx_entry_t newEntry;

    assign mode    = s_q.cfg.fmtCtl[FMT_MODE_LSB +: 2];
    assign spiHost = (mode == MODE_SPI);
    assign nineLow = (s_q.cfg.fmtCtl[2:0] == CHS_9LOW);
    assign linMode = (s_q.cfg.rxTxCtl[RECEIVE_MODE_SELECT_LSB +: 2] == RECEIVE_MODE_SELECT_LIN); // [R18]
    assign wStat   = bus.wr && (bus.addr == ADDR_STATUS);

    // advancing byte depends on character size
    assign pop = bus.rd && (s_q.rxCount != 2'h0)
        && ((nineLow && bus.addr == ADDR_RXH)                   // [R09]
        || (!nineLow && bus.addr == ADDR_RXL));                 // [R09]
    assign push = rxFrameValid && (s_q.rxCount != RXBUF_FULL);

    always_comb
    begin
        newEntry = '0;
        newEntry.data[7:0] = rxFrame.data[7:0];
        if (linMode)
        begin
            newEntry.data[8] = rxFrame.inResponse;              // [R17]
        end
        else if (s_q.cfg.fmtCtl[2:0] == CHS_9LOW
                 || s_q.cfg.fmtCtl[2:0] == CHS_9HIGH)
        begin
            newEntry.data[8] = rxFrame.data[8];                 // [R16]
        end
        newEntry.framing_error_flag = !spiHost && !rxFrame.stopBit;           // [R14]
        newEntry.parity_error_flag = !spiHost && s_q.cfg.fmtCtl[FMT_PAR_EN]
                        && rxFrame.parityBad;                   // [R15]
    end

    always_comb
    begin
        s_d = s_q;
        s_d.rdData = RESET_BYTE;
        s_d.txLoad = 1'b0;

        // receive buffer: pop the oldest, then append
        if (pop)
        begin
            s_d.rxBuf[0] = s_q.rxBuf[1];
            s_d.rxCount  = s_q.rxCount - 2'h1;
        end
        if (push)
        begin
            s_d.rxBuf[s_d.rxCount[0]] = newEntry;
            s_d.rxCount = s_d.rxCount + 2'h1;
        end
        s_d.rxReady = (s_d.rxCount != RXBUF_FULL);

        // overrun: data read clears, a new event wins
        if (bus.rd && (bus.addr == ADDR_RXL || bus.addr == ADDR_RXH))
        begin
            s_d.overrun = 1'b0;                                 // [R13]
        end
        if (s_q.rxCount == RXBUF_FULL && rxFrameValid && rxStartBit
            && !spiHost)
        begin
            s_d.overrun = 1'b1;                                 // [R13]
        end

        // sticky flags: write-one clears, hardware set wins
        if (wStat)
        begin
            if (bus.wrData[BIT_TXDONE])
            begin
                s_d.txDoneIf = 1'b0;
            end
            if (bus.wrData[BIT_RXSTART])
            begin
                s_d.rxStartIf = 1'b0;
            end
            if (bus.wrData[BIT_BADSYNC])
            begin
                s_d.badSyncIf = 1'b0;
            end
            if (bus.wrData[BIT_BREAK])
            begin
                s_d.breakIf = 1'b0;
            end
            s_d.cfg.waitBreak = bus.wrData[BIT_WAITBRK];
        end
        if (push)
        begin
            s_d.breakIf = 1'b0;
        end
        if (txShiftDone && txBufEmpty)
        begin
            s_d.txDoneIf = 1'b1;                                // [R05] [R06]
        end
        if (rxStartSleep)
        begin
            s_d.rxStartIf = 1'b1;                               // [R06]
        end
        if (syncError)
        begin
            s_d.badSyncIf = 1'b1;                               // [R06]
        end
        if (breakDetected)
        begin
            s_d.breakIf = 1'b1;
        end
        s_d.txEmptyIf = txBufEmpty;                             // [R04]

        // register writes
        if (bus.wr)
        begin
            if (bus.addr == ADDR_TXL)
            begin
                s_d.txData[7:0] = bus.wrData;
                s_d.txLoad = !nineLow;
            end
            else if (bus.addr == ADDR_TXH)
            begin
                s_d.txData[8] = bus.wrData[0];
                s_d.txLoad = nineLow;
            end
            else if (bus.addr == ADDR_IRQCTL)
            begin
                s_d.irqCtl = bus.wrData;
            end
            else if (bus.addr == ADDR_RXTXCT)
            begin
                s_d.cfg.rxTxCtl = bus.wrData;
            end
            else if (bus.addr == ADDR_FMTCTL)
            begin
                s_d.cfg.fmtCtl = bus.wrData;
            end
            else if (bus.addr == ADDR_BAUDL)
            begin
                s_d.cfg.baud[7:0] = bus.wrData;
            end
            else if (bus.addr == ADDR_BAUDH)
            begin
                s_d.cfg.baud[15:8] = bus.wrData;
            end
            else if (bus.addr == ADDR_ABWIN)
            begin
                s_d.cfg.abWin = bus.wrData;
            end
            else if (bus.addr == ADDR_DBG)
            begin
                s_d.cfg.dbg = bus.wrData;
            end
            else if (bus.addr == ADDR_EVIN)
            begin
                s_d.cfg.evIn = bus.wrData;
            end
            else if (bus.addr == ADDR_TXPL)
            begin
                s_d.cfg.txPl = bus.wrData;
            end
            else if (bus.addr == ADDR_RXPL)
            begin
                s_d.cfg.rxPl = bus.wrData;
            end
        end

        // register reads, data valid the following cycle
        if (bus.rd)
        begin
            if (bus.addr == ADDR_RXL)
            begin
                s_d.rdData = s_q.rxBuf[0].data[7:0];            // [R08]
            end
            else if (bus.addr == ADDR_RXH)
            begin
                s_d.rdData = '0;
                s_d.rdData[BIT_RXDONE] = (s_q.rxCount != 2'h0); // [R11] [R12]
                s_d.rdData[RXH_OVR]  = s_q.overrun;             // [R11]
                s_d.rdData[RXH_FRAMING_ERROR_FLAG] = s_q.rxBuf[0].framing_error_flag;
                s_d.rdData[RXH_PARITY_ERROR_FLAG] = s_q.rxBuf[0].parity_error_flag;
                s_d.rdData[0]        = s_q.rxBuf[0].data[8];
            end
            else if (bus.addr == ADDR_TXL)
            begin
                s_d.rdData = s_q.txData[7:0];
            end
            else if (bus.addr == ADDR_TXH)
            begin
                s_d.rdData = {7'h00, s_q.txData[8]};
            end
            else if (bus.addr == ADDR_STATUS)
            begin
                s_d.rdData = {s_q.rxCount != 2'h0, s_q.txDoneIf,
                              s_q.txEmptyIf, s_q.rxStartIf,
                              s_q.badSyncIf, 1'b0, s_q.breakIf, 1'b0};
            end
            else if (bus.addr == ADDR_IRQCTL)
            begin
                s_d.rdData = s_q.irqCtl;
            end
            else if (bus.addr == ADDR_RXTXCT)
            begin
                s_d.rdData = s_q.cfg.rxTxCtl;
            end
            else if (bus.addr == ADDR_FMTCTL)
            begin
                s_d.rdData = s_q.cfg.fmtCtl;
            end
            else if (bus.addr == ADDR_BAUDL)
            begin
                s_d.rdData = s_q.cfg.baud[7:0];
            end
            else if (bus.addr == ADDR_BAUDH)
            begin
                s_d.rdData = s_q.cfg.baud[15:8];
            end
            else if (bus.addr == ADDR_ABWIN)
            begin
                s_d.rdData = s_q.cfg.abWin;
            end
            else if (bus.addr == ADDR_DBG)
            begin
                s_d.rdData = s_q.cfg.dbg;
            end
            else if (bus.addr == ADDR_EVIN)
            begin
                s_d.rdData = s_q.cfg.evIn;
            end
            else if (bus.addr == ADDR_TXPL)
            begin
                s_d.rdData = s_q.cfg.txPl;
            end
            else if (bus.addr == ADDR_RXPL)
            begin
                s_d.rdData = s_q.cfg.rxPl;
            end
        end

        // vectors follow the next flag values so they move with them
        s_d.rxDoneVec =
            ((s_d.rxCount != 2'h0) && s_d.irqCtl[BIT_RXDONE])    // [R03] [R07]
            || (s_d.rxStartIf && s_d.irqCtl[BIT_RXSTART])       // [R03]
            || (s_d.badSyncIf && s_d.irqCtl[BIT_ABERRIE]);      // [R03]
        s_d.txEmptyVec = s_d.txEmptyIf && s_d.irqCtl[BIT_TXEMPTY]; // [R04]
        s_d.txDoneVec  = s_d.txDoneIf && s_d.irqCtl[BIT_TXDONE];   // [R07]
        s_d.irq = s_d.rxDoneVec || s_d.txEmptyVec || s_d.txDoneVec;

        // transfer clock event only when this end drives it
        s_d.xckOut = transferClkIn && xckIsOutput
                     && (mode == MODE_SYNC || spiHost);         // [R01]
        s_d.irPrev  = infraredEventInput;
        s_d.irEvent = s_q.cfg.evIn[EV_IR_EN] && infraredEventInput
                      && !s_q.irPrev;                           // [R02]
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.rxReady <= 1'b1;
            s_q.txEmptyIf <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign regRdData           = s_q.rdData;
    assign rxReady             = s_q.rxReady;
    assign txData              = s_q.txData;
    assign txLoad              = s_q.txLoad;
    assign transferClockOut    = s_q.xckOut;
    assign irRxEvent           = s_q.irEvent;
    assign receiveDoneVector   = s_q.rxDoneVec;
    assign txBufferEmptyVector = s_q.txEmptyVec;
    assign txDoneVector        = s_q.txDoneVec;
    assign irq                 = s_q.irq;
    assign cfg                 = s_q.cfg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_rx_done_bit;
        bus.rd && bus.addr == ADDR_RXH
            |=> regRdData[BIT_RXDONE] == ($past(s_q.rxCount) != 2'h0);
    endproperty
    a_rx_done_bit: assert property (p_rx_done_bit) // [R12]
        else $error("receive-done bit disagrees with buffer fill");

    property p_rx_vec;
        ##1 (s_q.rxCount != 2'h0 && s_q.irqCtl[BIT_RXDONE])
            |-> receiveDoneVector;
    endproperty
    a_rx_vec: assert property (p_rx_vec) // [R07]
        else $error("receive vector missing with unread data");

    property p_sync_vec;
        ##1 (s_q.badSyncIf && s_q.irqCtl[BIT_ABERRIE]) |-> receiveDoneVector;
    endproperty
    a_sync_vec: assert property (p_sync_vec) // [R03]
        else $error("receive vector missing on sync error");

    property p_tx_empty_vec;
        txBufferEmptyVector |-> $past(txBufEmpty) && s_q.irqCtl[BIT_TXEMPTY];
    endproperty
    a_tx_empty_vec: assert property (p_tx_empty_vec) // [R04]
        else $error("tx-empty vector without empty buffer and enable");

    property p_tx_done_set;
        txShiftDone && txBufEmpty |=> s_q.txDoneIf ##0 s_q.txDoneIf[*1];
    endproperty
    a_tx_done_set: assert property (p_tx_done_set) // [R05]
        else $error("tx-done flag not set after frame left");

    property p_advance;
        bus.rd && bus.addr == ADDR_RXL && !nineLow && !rxFrameValid
            && s_q.rxCount == RXBUF_FULL |=> s_q.rxCount == 2'h1;
    endproperty
    a_advance: assert property (p_advance) // [R09]
        else $error("low byte read did not advance buffer");

    property p_overrun;
        s_q.rxCount == RXBUF_FULL && rxFrameValid && rxStartBit && !spiHost
            |=> s_q.overrun;
    endproperty
    a_overrun: assert property (p_overrun) // [R13]
        else $error("overrun not flagged");

    property p_framing_error_flag;
        rxFrameValid && s_q.rxCount == 2'h0 && !spiHost
            |=> s_q.rxBuf[0].framing_error_flag == !$past(rxFrame.stopBit);
    endproperty
    a_framing_error_flag: assert property (p_framing_error_flag) // [R14]
        else $error("framing error does not follow stop bit");

    property p_lin_bit;
        rxFrameValid && s_q.rxCount == 2'h0 && linMode
            |=> s_q.rxBuf[0].data[8] == $past(rxFrame.inResponse);
    endproperty
    a_lin_bit: assert property (p_lin_bit) // [R17]
        else $error("ninth bit wrong in lin auto-baud mode");

    property p_ir_pulse;
        irRxEvent |-> $past(infraredEventInput) && !$past(infraredEventInput, 2);
    endproperty
    a_ir_pulse: assert property (p_ir_pulse) // [R02]
        else $error("infrared event without rising input");

    property p_xck;
        ##1 $past(xckIsOutput) && $past(mode) == MODE_SYNC
            |-> transferClockOut == $past(transferClkIn);
    endproperty
    a_xck: assert property (p_xck) // [R01]
        else $error("transfer clock event does not follow clock");
endmodule : uie_usart_irq_rx
`default_nettype wire

// [src/uie_pkg.sv]
// constants, register map and carrier types for the usart irq/readout block
package uie_pkg;
    localparam logic [3:0] ADDR_RXL    = 4'h0;
    localparam logic [3:0] ADDR_RXH    = 4'h1;
    localparam logic [3:0] ADDR_TXL    = 4'h2;
    localparam logic [3:0] ADDR_TXH    = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQCTL = 4'h5;
    localparam logic [3:0] ADDR_RXTXCT = 4'h6;
    localparam logic [3:0] ADDR_FMTCTL = 4'h7;
    localparam logic [3:0] ADDR_BAUDL  = 4'h8;
    localparam logic [3:0] ADDR_BAUDH  = 4'h9;
    localparam logic [3:0] ADDR_ABWIN  = 4'hA;
    localparam logic [3:0] ADDR_DBG    = 4'hB;
    localparam logic [3:0] ADDR_EVIN   = 4'hC;
    localparam logic [3:0] ADDR_TXPL   = 4'hD;
    localparam logic [3:0] ADDR_RXPL   = 4'hE;
    // status / interrupt-control bit positions
    localparam int BIT_RXDONE  = 7;
    localparam int BIT_TXDONE  = 6;
    localparam int BIT_TXEMPTY = 5;
    localparam int BIT_RXSTART = 4;
    localparam int BIT_BADSYNC = 3;
    localparam int BIT_ABERRIE = 2;
    localparam int BIT_BREAK   = 1;
    localparam int BIT_WAITBRK = 0;
    // receive high byte bit positions
    localparam int RXH_OVR  = 6;
    localparam int RXH_FRAMING_ERROR_FLAG = 2;
    localparam int RXH_PARITY_ERROR_FLAG = 1;
    // frame format fields
    localparam int FMT_MODE_LSB = 6;
    localparam int FMT_PAR_EN   = 5;
    localparam logic [1:0] MODE_SYNC = 2'h1;
    localparam logic [1:0] MODE_SPI  = 2'h3;
    localparam logic [2:0] CHS_9LOW  = 3'h6;
    localparam logic [2:0] CHS_9HIGH = 3'h7;
    localparam int RECEIVE_MODE_SELECT_LSB = 1;
    localparam logic [1:0] RECEIVE_MODE_SELECT_LIN = 2'h3;
    localparam int EV_IR_EN = 0;
    localparam logic [1:0] RXBUF_FULL = 2'h2;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef struct packed {
        logic [8:0] data;
        logic       stopBit;
        logic       parityBad;
        logic       inResponse;
    } uie_rx_frame_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wrData;
        logic       wr;
        logic       rd;
    } uie_bus_t;

    typedef struct packed {
        logic [7:0]  rxTxCtl;
        logic [7:0]  fmtCtl;
        logic [15:0] baud;
        logic [7:0]  abWin;
        logic [7:0]  dbg;
        logic [7:0]  evIn;
        logic [7:0]  txPl;
        logic [7:0]  rxPl;
        logic        waitBreak;
    } uie_cfg_t;

    typedef struct packed {
        logic [8:0] data;
        logic       framing_error_flag;
        logic       parity_error_flag;
    } uie_rx_entry_t;

    typedef struct packed {
        uie_rx_entry_t [1:0] rxBuf;
        logic [1:0]  rxCount;
        logic        overrun;
        logic        txDoneIf;
        logic        txEmptyIf;
        logic        rxStartIf;
        logic        badSyncIf;
        logic        breakIf;
        logic [7:0]  irqCtl;
        uie_cfg_t    cfg;
        logic [8:0]  txData;
        logic        txLoad;
        logic [7:0]  rdData;
        logic        rxDoneVec;
        logic        txEmptyVec;
        logic        txDoneVec;
        logic        irq;
        logic        xckOut;
        logic        irPrev;
        logic        irEvent;
        logic        rxReady;
    } uie_state_t;
endpackage : uie_pkg

// [sim/uie_rx_source.sv]
// behavioural receiver core that offers completed frames to the readout
`timescale 1ns/1ps
`default_nettype none
module uie_rx_source
    import uie_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          rxReady,
    input  wire logic          sendReq,
    input  wire uie_rx_frame_t sendFrame,
    output logic               rxFrameValid,
    output uie_rx_frame_t      rxFrame
);
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rxFrameValid <= 1'b0;
            rxFrame      <= '0;
        end
        else if (rxFrameValid && rxReady)
        begin
            rxFrameValid <= 1'b0;
            rxFrame      <= ~rxFrame;
        end
        else if (sendReq && !rxFrameValid)
        begin
            // frame waits in the shift register until taken
            rxFrameValid <= 1'b1;
            rxFrame      <= sendFrame;
        end
        else if (!rxFrameValid)
        begin
            // idle lines keep moving so stale data never looks valid
            rxFrame <= ~rxFrame;
        end
    end
endmodule : uie_rx_source
`default_nettype wire

// [sim/uie_usart_irq_rx_tb.sv]
// self-checking bench for the usart irq and receive readout block
`timescale 1ns/1ps
`default_nettype none
module uie_usart_irq_rx_tb
    import uie_pkg::*;
;
    typedef struct packed {
        logic [7:0]    rxtx;
        logic [7:0]    fmt;
        uie_rx_frame_t f;
        logic [7:0]    expL;
        logic [7:0]    expH;
    } uie_row_t;
    localparam uie_row_t ROWS [8] = '{
        '{8'hC0, 8'h03, '{9'h05A, 1'b1, 1'b1, 1'b0}, 8'h5A, 8'h80},
        '{8'hC0, 8'h23, '{9'h0C3, 1'b1, 1'b1, 1'b0}, 8'hC3, 8'h82},
        '{8'hC0, 8'h03, '{9'h03C, 1'b0, 1'b0, 1'b0}, 8'h3C, 8'h84},
        '{8'hC0, 8'h07, '{9'h1A5, 1'b1, 1'b0, 1'b0}, 8'hA5, 8'h81},
        '{8'hC0, 8'h06, '{9'h1F0, 1'b1, 1'b0, 1'b0}, 8'hF0, 8'h81},
        '{8'hC6, 8'h03, '{9'h011, 1'b1, 1'b0, 1'b1}, 8'h11, 8'h81},
        '{8'hC6, 8'h03, '{9'h122, 1'b1, 1'b0, 1'b0}, 8'h22, 8'h80},
        '{8'hC0, 8'h03, '{9'h1EE, 1'b1, 1'b0, 1'b0}, 8'hEE, 8'h80}
    };
    localparam logic [7:0] XMODE [3] = '{8'hC3, 8'h43, 8'h03};
    logic          clk                = 1'b0;
    logic          rst                = 1'b1;
    uie_bus_t      bus                = '0;
    logic [7:0]    regRdData;
    logic          rxFrameValid;
    uie_rx_frame_t rxFrame;
    logic          rxReady;
    logic          rxStartBit         = 1'b0;
    logic          rxStartSleep       = 1'b0;
    logic          syncError          = 1'b0;
    logic          txBufEmpty         = 1'b1;
    logic          txShiftDone        = 1'b0;
    logic          transferClkIn      = 1'b0;
    logic          xckIsOutput        = 1'b1;
    logic          transferClockOut;
    logic          infraredEventInput = 1'b0;
    logic          irRxEvent;
    logic          receiveDoneVector;
    logic          txBufferEmptyVector;
    logic          txDoneVector;
    logic          irq;
    logic [8:0]    txData;
    logic          txLoad;
    uie_cfg_t      cfg;
    logic          sendReq            = 1'b0;
    uie_rx_frame_t sendFrame          = '0;
    int            errors             = 0;
    int            testsRun           = 0;
    int            cycles             = 0;

    always #20 clk = ~clk;

    uie_usart_irq_rx uie_usart_irq_rx_inst (
        .clk(clk), .rst(rst), .bus(bus), .regRdData(regRdData),
        .rxFrameValid(rxFrameValid), .rxFrame(rxFrame), .rxReady(rxReady),
        .rxStartBit(rxStartBit), .rxStartSleep(rxStartSleep),
        .syncError(syncError), .breakDetected(1'b0),
        .txBufEmpty(txBufEmpty), .txShiftDone(txShiftDone), .txData(txData),
        .txLoad(txLoad), .transferClkIn(transferClkIn),
        .xckIsOutput(xckIsOutput),
        .transferClockOut(transferClockOut),
        .infraredEventInput(infraredEventInput), .irRxEvent(irRxEvent),
        .receiveDoneVector(receiveDoneVector),
        .txBufferEmptyVector(txBufferEmptyVector),
        .txDoneVector(txDoneVector), .irq(irq), .cfg(cfg)
    );

    uie_rx_source uie_rx_source_inst (
        .clk(clk), .rst(rst), .rxReady(rxReady), .sendReq(sendReq),
        .sendFrame(sendFrame), .rxFrameValid(rxFrameValid),
        .rxFrame(rxFrame)
    );

    task automatic report_and_stop;
        $display("checks %0d errors %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string n, input logic [8:0] e,
                       input logic [8:0] g);
        testsRun++;
        if (g !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus.addr   <= a;
        bus.wrData <= d;
        bus.wr     <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [3:0] a, input logic [7:0] m,
                       input logic [7:0] e, input string n);
        @(posedge clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk(n, e, regRdData & m);
    endtask : rdc

    task automatic send(input uie_rx_frame_t f);
        @(posedge clk);
        sendReq   <= 1'b1;
        sendFrame <= f;
        @(posedge clk);
        sendReq <= 1'b0;
        @(posedge clk);
        #1 chk("frame taken", 9'h000, rxFrameValid);
    endtask : send

    task automatic pulse(input int s);
        @(posedge clk);
        case (s)
            0: rxStartSleep <= 1'b1;
            1: syncError <= 1'b1;
            2: txShiftDone <= 1'b1;
            3: rxStartBit <= 1'b1;
            default: infraredEventInput <= 1'b1;
        endcase
        @(posedge clk);
        {rxStartSleep, syncError, txShiftDone} <= 3'h0;
        {rxStartBit, infraredEventInput} <= 2'h0;
    endtask : pulse

    task automatic vecs(input logic [3:0] e, input string n);
        repeat (2) @(posedge clk);
        #1 chk(n, e, {irq, receiveDoneVector, txBufferEmptyVector,
                      txDoneVector});
    endtask : vecs

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            report_and_stop();
        end
    end

    initial
    begin
        logic [7:0] e;
        logic       lf;
        logic [3:0] a;
        logic [3:0] irCount;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdc(ADDR_RXL, 8'hFF, 8'h00, "rxl reset");
        rdc(ADDR_RXH, 8'hFF, 8'h00, "rxh reset");
        wr(ADDR_RXL, 8'hFF);
        rdc(ADDR_RXL, 8'hFF, 8'h00, "rxl read only");
        rdc(4'hF, 8'hFF, 8'h00, "unmapped");
        foreach (ROWS[i])
        begin
            wr(ADDR_RXTXCT, ROWS[i].rxtx);
            wr(ADDR_FMTCTL, ROWS[i].fmt);
            send(ROWS[i].f);
            lf = ROWS[i].fmt[2:0] == CHS_9LOW;
            for (int k = 0; k < 2; k++)
            begin
                a = ((k == 0) == lf) ? ADDR_RXL : ADDR_RXH;
                e = a == ADDR_RXL ? ROWS[i].expL : ROWS[i].expH;
                rdc(a, 8'hFF, e, "rx byte");
            end
            rdc(ADDR_STATUS, 8'h80, 8'h00, "rx empty");
        end
        wr(ADDR_RXTXCT, 8'hC0);
        wr(ADDR_FMTCTL, 8'h03);
        send('{9'h011, 1'b1, 1'b0, 1'b0});
        send('{9'h022, 1'b1, 1'b0, 1'b0});
        @(posedge clk);
        #1 chk("buffer full", 9'h000, rxReady);
        @(posedge clk);
        sendReq   <= 1'b1;
        sendFrame <= '{9'h033, 1'b1, 1'b0, 1'b0};
        @(posedge clk);
        sendReq <= 1'b0;
        pulse(3);
        rdc(ADDR_RXH, 8'hFF, 8'hC0, "overrun set");
        rdc(ADDR_RXL, 8'hFF, 8'h11, "oldest");
        rdc(ADDR_RXH, 8'hFF, 8'h80, "overrun cleared");
        rdc(ADDR_RXL, 8'hFF, 8'h22, "second");
        rdc(ADDR_RXH, 8'hFF, 8'h80, "third status");
        rdc(ADDR_RXL, 8'hFF, 8'h33, "third");
        send('{9'h044, 1'b1, 1'b0, 1'b0});
        rdc(ADDR_STATUS, 8'h80, 8'h80, "flag unenabled");
        vecs(4'h0, "no request");
        wr(ADDR_IRQCTL, 8'h80);
        vecs(4'hC, "rx request");
        rdc(ADDR_RXL, 8'hFF, 8'h44, "pop");
        vecs(4'h0, "rx drained");
        wr(ADDR_IRQCTL, 8'h10);
        pulse(0);
        rdc(ADDR_STATUS, 8'h10, 8'h10, "start flag");
        vecs(4'hC, "start request");
        wr(ADDR_STATUS, 8'h10);
        vecs(4'h0, "start cleared");
        wr(ADDR_IRQCTL, 8'h04);
        pulse(1);
        rdc(ADDR_STATUS, 8'h08, 8'h08, "sync flag");
        vecs(4'hC, "sync request");
        wr(ADDR_STATUS, 8'h08);
        vecs(4'h0, "sync cleared");
        wr(ADDR_IRQCTL, 8'h20);
        vecs(4'hA, "empty request");
        @(posedge clk);
        txBufEmpty <= 1'b0;
        vecs(4'h0, "tx buffer full");
        wr(ADDR_IRQCTL, 8'h40);
        pulse(2);
        vecs(4'h0, "tx data waiting");
        @(posedge clk);
        txBufEmpty <= 1'b1;
        pulse(2);
        vecs(4'h9, "tx done request");
        wr(ADDR_STATUS, 8'h40);
        vecs(4'h0, "tx done cleared");
        wr(ADDR_TXL, 8'h5A);
        #1 chk("tx load", 9'h15A, {txLoad, txData[7:0]});
        chk("cfg", 9'h003, {1'b0, cfg.fmtCtl});
        foreach (XMODE[j])
        begin
            wr(ADDR_FMTCTL, XMODE[j]);
            for (int n = 0; n < 4; n++)
            begin
                @(posedge clk);
                transferClkIn <= ~transferClkIn;
                @(posedge clk);
                #1 e = XMODE[j] == 8'h03 ? 8'h00 : {7'h00, transferClkIn};
                chk("transfer clock", e, transferClockOut);
            end
        end
        for (int n = 0; n < 2; n++)
        begin
            wr(ADDR_EVIN, n == 0 ? 8'h01 : 8'h00);
            irCount = 4'h0;
            pulse(4);
            for (int c = 0; c < 4; c++)
            begin
                #1 irCount = irCount + {3'h0, irRxEvent};
                @(posedge clk);
            end
            chk("ir events", n == 0 ? 9'h001 : 9'h000, irCount);
        end
        report_and_stop();
    end
endmodule : uie_usart_irq_rx_tb
`default_nettype wire
